// file: design/cyc_pkg.sv
// Purpose: Constants and types for the transaction cycle accountant
// Assumes: Cost columns are ordered {4x, 2x, 1x}, so index 0 is 1x
// Notes: All costs are processor clock cycles; fill counts are bytes and fetch counts are words
package cyc_pkg;
    typedef logic [9:0] cost_t;
    typedef logic [2:0][9:0] col_t;

    typedef enum logic [5:0] {
        K_FETCH_CACHE, K_FETCH_EXT, K_FETCH_BURST, K_READ, K_TEST_AND_SET_OP_CACHE, K_TEST_AND_SET_OP_FIXED,
        K_WRITE, K_PAGE_FAULT, K_IN_INT, K_IN_EXT, K_OUT_INT, K_EPU_IF, K_EPU_CPU,
        K_EPU_WR, K_EPU_RD, K_IACK_NMI, K_IACK_M0, K_IACK_M123, K_HALT_TR, K_RESET_TR,
        K_RETI_TR, K_TEMPLATE, K_EPU_INT, K_EPU_XFER, K_EPU_MEM, K_TRAP_DIV_AV,
        K_TRAP_STEP, K_TRAP_SC, K_TRAP_EPU_A, K_TRAP_EPU_MEM, K_INT_13, K_INT_M0,
        K_INT_M2, K_INT_M3, K_INT_M3V, K_FATAL, K_RESET_PROC
    } kind_t;

    typedef enum logic {S_IDLE, S_RUN} state_t;

    localparam cost_t FETCH_CACHE_FIRST = 10'h004;
    localparam cost_t FETCH_CACHE_NEXT = 10'h001;
    localparam col_t FETCH_EXT_FIRST = {10'h011, 10'h00C, 10'h009};
    localparam col_t FETCH_EXT_NEXT = {10'h00D, 10'h008, 10'h005};
    localparam col_t FETCH_BURST_FIRST = {10'h01D, 10'h012, 10'h00C};
    localparam col_t FETCH_BURST_NEXT = {10'h019, 10'h00E, 10'h008};
    localparam cost_t DATA_HIT = 10'h005;
    localparam col_t DATA_MISS = {10'h010, 10'h00B, 10'h008};
    localparam cost_t UNAL_HIT_HIT = 10'h009;
    localparam col_t UNAL_ONE_MISS = {10'h014, 10'h00F, 10'h00C};
    localparam col_t UNAL_MISS_MISS = {10'h01F, 10'h015, 10'h00F};
    localparam cost_t TEST_AND_SET_OP_FIXED = 10'h006;
    localparam cost_t WRITE_SHORT = 10'h005;
    localparam col_t WRITE_UNAL = {10'h011, 10'h00C, 10'h009};
    localparam cost_t WRITE_UNAL_CACHED_EXTRA = 10'h001;
    localparam cost_t PAGE_FAULT = 10'h004;
    localparam cost_t IO_INTERNAL = 10'h005;
    localparam col_t IN_EXT = {10'h014, 10'h00D, 10'h009};
    localparam col_t EPU_IF = {10'h010, 10'h00B, 10'h008};
    localparam col_t EPU_CPU = {10'h014, 10'h00D, 10'h009};
    localparam col_t EPU_WR = {10'h018, 10'h00F, 10'h00A};
    localparam col_t EPU_RD = {10'h010, 10'h00B, 10'h008};
    localparam cost_t IACK_NMI = 10'h004;
    localparam col_t IACK_M0 = {10'h016, 10'h00D, 10'h008};
    localparam col_t IACK_M123 = {10'h018, 10'h00F, 10'h00A};
    localparam cost_t HALT_TR = 10'h005;
    localparam cost_t RESET_TR = 10'h006;
    localparam col_t RETI_TR = {10'h031, 10'h01F, 10'h015};
    localparam cost_t TEMPLATE = 10'h007;
    localparam cost_t EPU_INT = 10'h004;
    localparam cost_t EPU_XFER = 10'h006;
    localparam cost_t EPU_MEM = 10'h005;
    localparam cost_t TRAP_DIV_AV = 10'h019;
    localparam cost_t TRAP_STEP = 10'h01A;
    localparam cost_t TRAP_SC = 10'h01E;
    localparam cost_t TRAP_EPU_A = 10'h01F;
    localparam cost_t TRAP_EPU_MEM = 10'h026;
    localparam cost_t INT_13 = 10'h00D;
    localparam cost_t INT_M0 = 10'h009;
    localparam cost_t INT_M2 = 10'h010;
    localparam cost_t INT_M3 = 10'h01C;
    localparam cost_t INT_M3V = 10'h01F;
    localparam cost_t FATAL_MIN = 10'h00F;
    localparam cost_t RESET_PROC_MIN = 10'h003;
    localparam cost_t ADDR_ONE = 10'h001;
    localparam cost_t ADDR_TWO = 10'h002;
    localparam logic [1:0] MODE_BX = 2'h2;
    localparam logic [15:0] BURST_MASK = 16'hFFF8;
    localparam logic [15:0] WORD_MASK = 16'hFFFE;
    localparam logic [2:0] BURST_FILL = 3'h7;
    localparam logic [2:0] WORD_FILL = 3'h1;
    localparam logic [1:0] IFN_ALIGNED = 2'h1;
    localparam logic [1:0] IFN_UNALIGNED = 2'h2;
    localparam logic FIRST_PENDING_RST = 1'b1;
endpackage

// file: design/cyc_timer.sv
// Purpose: Cycle accountant for bus transactions, fetch, exceptions and flushes
// Assumes: One request at a time; RATIO 0=1x, 1=2x, 2 or 3=4x
// Notes: Waits and pause arrive on pins and are synchronised
// Overview of operation
// RULE_01 - Pause holds off start and stretches coprocessor work
// RULE_02 - Template fetch base 7, one or two further words
// RULE_03 - Coprocessor word count from template byte count
// RULE_04 - Address modes add zero, one or two cycles
// RULE_05 - Flush pipeline after interrupt or trap entry
// RULE_06 - Trap entry bases 25, 30 and 38
// RULE_07 - Interrupt entry bases 16, 28 and 31
// RULE_08 - Fatal at least 15, reset at least 3
// RULE_09 - First cached byte costs 4, later 1
// RULE_10 - Slow bus ratios add phase alignment cycles
// RULE_11 - Sixteen-bit fetch caches the unrequested byte
// RULE_12 - Burst moves eight-byte aligned four-word block
// RULE_13 - Waits counted exclude built-in transaction waits
// RULE_14 - Aligned means even address on sixteen-bit bus
// RULE_15 - Reads cost 5, 9, or 15 plus waits
// RULE_16 - Page fault takes 4 then access trap
// RULE_17 - Writes 5; unaligned cached first 10 or 9+w
// RULE_18 - Flush when written byte valid in cache
// RULE_19 - Internal I/O 5, external read 9+w
// RULE_20 - Coprocessor transfers 8, 9, 10 plus waits
// RULE_21 - Acknowledge costs 4, 10+w, 8+w per byte
// RULE_22 - Halt 5, reset 6, return 21+w
// RULE_23 - Bus clock ratio input picks cost column
// RULE_24 - Outside parties signal waits on wait pin
`timescale 1ns/10ps
module cyc_timer (
    input wire logic CLK,                 // Processor clock
    input wire logic RST,                 // Synchronous reset
    input wire logic REQ,                 // Start a transaction
    input wire logic [5:0] KIND,          // Transaction kind code
    input wire logic [1:0] RATIO,         // Bus clock ratio select
    input wire logic [15:0] ADDR,         // Access address
    input wire logic WORD,                // Word access
    input wire logic BUS16,               // Transfer on sixteen-bit bus
    input wire logic HIT_FIRST,           // First byte in cache
    input wire logic HIT_SECOND,          // Second byte in cache
    input wire logic [1:0] ADDR_MODE,     // 0 none, 1 indexed class, 2 base index
    input wire logic [7:0] NBYTES,        // Template byte count
    input wire logic WRITE_IN_CACHE,      // Written byte valid in cache
    input wire logic WAIT_PIN,            // External wait request
    input wire logic PAUSE_PIN,           // Pause request
    output logic BUSY,                    // Transaction in progress
    output logic DONE,                    // Transaction finished pulse
    output logic [9:0] CYCLES,            // Cycles of last transaction
    output logic FLUSH,                   // Pipeline flush pulse
    output logic TRAP_AV,                 // Access violation trap pulse
    output logic [7:0] KWORDS,            // Coprocessor word transfers
    output logic [15:0] BLOCK_ADDR,       // Fetched word or block address
    output logic [2:0] FILL_BYTES,        // Extra bytes placed in cache
    output logic [1:0] FOLLOW_FETCHES,    // Further template words to fetch
    output logic FIRST_PENDING            // Next fetch counts as first byte
);
    typedef struct packed {
        cyc_pkg::state_t state;
        cyc_pkg::kind_t kind;
        cyc_pkg::cost_t remain;
        cyc_pkg::cost_t count;
        logic [1:0] bus_phase;
        logic [2:0] wait_sync;
        logic [2:0] pause_sync;
        logic wait_lvl;
        logic pause_lvl;
        logic ext;
        logic skip_wait;
        logic wr_hit;
        logic first;
        logic busy;
        logic done;
        logic flush;
        logic trap;
        cyc_pkg::cost_t cycles;
        logic [7:0] kwords;
        logic [15:0] block_addr;
        logic [2:0] fill;
        logic [1:0] follow_ifn;
    } st_t;

    st_t st;
    st_t next_st;
    logic start;
    logic aligned;
    cyc_pkg::kind_t kind_in;
    cyc_pkg::cost_t cost;

    function automatic logic [2:0] ratio_n(input logic [1:0] r);
        return (r == 2'h0) ? 3'h1 : (r == 2'h1) ? 3'h2 : 3'h4;
    endfunction

    function automatic cyc_pkg::cost_t pick(input cyc_pkg::col_t c, input logic [1:0] r);
        return (r == 2'h0) ? c[0] : (r == 2'h1) ? c[1] : c[2]; // RULE_23
    endfunction

    function automatic logic epu_instr(input cyc_pkg::kind_t k);
        return k inside {cyc_pkg::K_EPU_INT, cyc_pkg::K_EPU_XFER, cyc_pkg::K_EPU_MEM};
    endfunction

    function automatic logic is_entry(input cyc_pkg::kind_t k);
        return k inside {cyc_pkg::K_TRAP_DIV_AV, cyc_pkg::K_TRAP_STEP, cyc_pkg::K_TRAP_SC,
            cyc_pkg::K_TRAP_EPU_A, cyc_pkg::K_TRAP_EPU_MEM, cyc_pkg::K_INT_13,
            cyc_pkg::K_INT_M0, cyc_pkg::K_INT_M2, cyc_pkg::K_INT_M3, cyc_pkg::K_INT_M3V};
    endfunction

    function automatic logic needs_bus(input cyc_pkg::kind_t k, input logic w, input logic al,
                                       input logic h1, input logic h2);
        unique case (k)
            cyc_pkg::K_FETCH_EXT, cyc_pkg::K_FETCH_BURST, cyc_pkg::K_TEST_AND_SET_OP_CACHE,
            cyc_pkg::K_IN_EXT, cyc_pkg::K_EPU_IF, cyc_pkg::K_EPU_CPU, cyc_pkg::K_EPU_WR,
            cyc_pkg::K_EPU_RD, cyc_pkg::K_IACK_M0, cyc_pkg::K_IACK_M123,
            cyc_pkg::K_RETI_TR: return 1'b1;
            cyc_pkg::K_READ: return (!w || al) ? !h1 : !(h1 && h2);
            cyc_pkg::K_WRITE: return w && !al;
            default: return 1'b0;
        endcase
    endfunction

    function automatic cyc_pkg::cost_t base_cost(input cyc_pkg::kind_t k, input logic [1:0] r,
            input logic fst, input logic w, input logic al, input logic h1, input logic h2);
        unique case (k)
            cyc_pkg::K_FETCH_CACHE: return fst ? cyc_pkg::FETCH_CACHE_FIRST
                                               : cyc_pkg::FETCH_CACHE_NEXT; // RULE_09
            cyc_pkg::K_FETCH_EXT: return fst ? pick(cyc_pkg::FETCH_EXT_FIRST, r)
                                             : pick(cyc_pkg::FETCH_EXT_NEXT, r);
            cyc_pkg::K_FETCH_BURST: return fst ? pick(cyc_pkg::FETCH_BURST_FIRST, r)
                                               : pick(cyc_pkg::FETCH_BURST_NEXT, r);
            cyc_pkg::K_READ: begin // RULE_15
                if (!w || al) begin
                    return h1 ? cyc_pkg::DATA_HIT : pick(cyc_pkg::DATA_MISS, r);
                end
                if (h1 && h2) begin
                    return cyc_pkg::UNAL_HIT_HIT;
                end
                return (h1 ^ h2) ? pick(cyc_pkg::UNAL_ONE_MISS, r) : pick(cyc_pkg::UNAL_MISS_MISS, r);
            end
            cyc_pkg::K_TEST_AND_SET_OP_CACHE: return pick(cyc_pkg::DATA_MISS, r);
            cyc_pkg::K_TEST_AND_SET_OP_FIXED: return cyc_pkg::TEST_AND_SET_OP_FIXED;
            cyc_pkg::K_WRITE: return (w && !al) ? pick(cyc_pkg::WRITE_UNAL, r) : cyc_pkg::WRITE_SHORT; // RULE_17
            cyc_pkg::K_PAGE_FAULT: return cyc_pkg::PAGE_FAULT; // RULE_16
            cyc_pkg::K_IN_INT, cyc_pkg::K_OUT_INT: return cyc_pkg::IO_INTERNAL; // RULE_19
            cyc_pkg::K_IN_EXT: return pick(cyc_pkg::IN_EXT, r); // RULE_19
            cyc_pkg::K_EPU_IF: return pick(cyc_pkg::EPU_IF, r); // RULE_20
            cyc_pkg::K_EPU_CPU: return pick(cyc_pkg::EPU_CPU, r); // RULE_20
            cyc_pkg::K_EPU_WR: return pick(cyc_pkg::EPU_WR, r); // RULE_20
            cyc_pkg::K_EPU_RD: return pick(cyc_pkg::EPU_RD, r); // RULE_20
            cyc_pkg::K_IACK_NMI: return cyc_pkg::IACK_NMI; // RULE_21
            cyc_pkg::K_IACK_M0: return pick(cyc_pkg::IACK_M0, r); // RULE_21
            cyc_pkg::K_IACK_M123: return pick(cyc_pkg::IACK_M123, r); // RULE_21
            cyc_pkg::K_HALT_TR: return cyc_pkg::HALT_TR; // RULE_22
            cyc_pkg::K_RESET_TR: return cyc_pkg::RESET_TR; // RULE_22
            cyc_pkg::K_RETI_TR: return pick(cyc_pkg::RETI_TR, r); // RULE_22
            cyc_pkg::K_TEMPLATE: return cyc_pkg::TEMPLATE; // RULE_02
            cyc_pkg::K_EPU_INT: return cyc_pkg::EPU_INT;
            cyc_pkg::K_EPU_XFER: return cyc_pkg::EPU_XFER;
            cyc_pkg::K_EPU_MEM: return cyc_pkg::EPU_MEM;
            cyc_pkg::K_TRAP_DIV_AV: return cyc_pkg::TRAP_DIV_AV; // RULE_06
            cyc_pkg::K_TRAP_STEP: return cyc_pkg::TRAP_STEP;
            cyc_pkg::K_TRAP_SC: return cyc_pkg::TRAP_SC; // RULE_06
            cyc_pkg::K_TRAP_EPU_A: return cyc_pkg::TRAP_EPU_A;
            cyc_pkg::K_TRAP_EPU_MEM: return cyc_pkg::TRAP_EPU_MEM; // RULE_06
            cyc_pkg::K_INT_13: return cyc_pkg::INT_13;
            cyc_pkg::K_INT_M0: return cyc_pkg::INT_M0;
            cyc_pkg::K_INT_M2: return cyc_pkg::INT_M2; // RULE_07
            cyc_pkg::K_INT_M3: return cyc_pkg::INT_M3; // RULE_07
            cyc_pkg::K_INT_M3V: return cyc_pkg::INT_M3V; // RULE_07
            cyc_pkg::K_FATAL: return cyc_pkg::FATAL_MIN; // RULE_08
            cyc_pkg::K_RESET_PROC: return cyc_pkg::RESET_PROC_MIN; // RULE_08
            default: return cyc_pkg::FETCH_CACHE_NEXT;
        endcase
    endfunction

    function automatic logic [7:0] kwords_of(input logic [7:0] n, input logic al);
        logic [8:0] n9;
        n9 = {1'b0, n};
        if (n[0]) begin
            return 8'((n9 + 9'h001) >> 1);
        end
        return al ? 8'(n9 >> 1) : 8'((n9 + 9'h002) >> 1);
    endfunction

    assign kind_in = cyc_pkg::kind_t'(KIND);
    assign aligned = !ADDR[0] && BUS16; // RULE_14
    assign start = (st.state == cyc_pkg::S_IDLE) && REQ && !st.pause_lvl; // RULE_01

    always_comb begin
        logic ext;
        logic [2:0] rn;
        ext = needs_bus(kind_in, WORD, aligned, HIT_FIRST, HIT_SECOND);
        rn = ratio_n(RATIO);
        next_st = st;
        next_st.done = 1'b0;
        next_st.flush = 1'b0;
        next_st.trap = 1'b0;
        // Three-stage synchronisers, level taken when stages two and three agree
        next_st.wait_sync = {st.wait_sync[1:0], WAIT_PIN}; // RULE_24
        next_st.pause_sync = {st.pause_sync[1:0], PAUSE_PIN};
        if (st.wait_sync[1] == st.wait_sync[2]) begin
            next_st.wait_lvl = st.wait_sync[1];
        end
        if (st.pause_sync[1] == st.pause_sync[2]) begin
            next_st.pause_lvl = st.pause_sync[1];
        end
        next_st.bus_phase = ({1'b0, st.bus_phase} + 3'h1 >= rn) ? 2'h0 : 2'(st.bus_phase + 2'h1);
        cost = base_cost(kind_in, RATIO, st.first, WORD, aligned, HIT_FIRST, HIT_SECOND);
        if (kind_in inside {cyc_pkg::K_READ, cyc_pkg::K_WRITE, cyc_pkg::K_EPU_MEM,
                            cyc_pkg::K_TRAP_EPU_MEM}) begin
            cost = cost + ((ADDR_MODE == cyc_pkg::MODE_BX) ? cyc_pkg::ADDR_TWO :
                           (ADDR_MODE != 2'h0) ? cyc_pkg::ADDR_ONE : 10'h000); // RULE_04
        end
        // Unaligned write with cached first byte at 1x: 10 for w of 0 or 1, else 9+w
        if (kind_in == cyc_pkg::K_WRITE && WORD && !aligned && HIT_FIRST && RATIO == 2'h0) begin
            cost = cost + cyc_pkg::WRITE_UNAL_CACHED_EXTRA; // RULE_17
        end
        // Phase left over from a wider ratio adds nothing
        if (ext && st.bus_phase != 2'h0 && {1'b0, st.bus_phase} < rn) begin
            cost = cyc_pkg::cost_t'(cost + cyc_pkg::cost_t'(rn - {1'b0, st.bus_phase})); // RULE_10
        end
        unique case (st.state)
            cyc_pkg::S_IDLE: begin
                if (start) begin
                    next_st.state = cyc_pkg::S_RUN;
                    next_st.busy = 1'b1;
                    next_st.kind = kind_in;
                    next_st.remain = cost;
                    next_st.count = 10'h000;
                    next_st.ext = ext;
                    next_st.wr_hit = WRITE_IN_CACHE;
                    next_st.skip_wait = (kind_in == cyc_pkg::K_WRITE) && WORD && !aligned
                                        && HIT_FIRST && RATIO == 2'h0; // RULE_17
                    if (kind_in inside {cyc_pkg::K_EPU_MEM, cyc_pkg::K_TRAP_EPU_MEM}) begin
                        next_st.kwords = kwords_of(NBYTES, aligned); // RULE_03
                    end
                    if (kind_in == cyc_pkg::K_TEMPLATE) begin
                        next_st.follow_ifn = aligned ? cyc_pkg::IFN_ALIGNED : cyc_pkg::IFN_UNALIGNED; // RULE_02
                    end
                    if (kind_in == cyc_pkg::K_FETCH_BURST) begin
                        next_st.block_addr = ADDR & cyc_pkg::BURST_MASK; // RULE_12
                        next_st.fill = cyc_pkg::BURST_FILL; // RULE_12
                    end else if (kind_in == cyc_pkg::K_FETCH_EXT) begin
                        next_st.block_addr = BUS16 ? (ADDR & cyc_pkg::WORD_MASK) : ADDR;
                        next_st.fill = BUS16 ? cyc_pkg::WORD_FILL : 3'h0; // RULE_11
                    end
                end
            end
            cyc_pkg::S_RUN: begin
                next_st.count = st.count + 10'h001;
                if (epu_instr(st.kind) && st.pause_lvl) begin
                    next_st.remain = st.remain; // RULE_01
                end else if (st.ext && st.wait_lvl && st.bus_phase == 2'h0 && !st.skip_wait) begin
                    // Each wait stretches by one bus clock; built-in waits are in the base
                    next_st.remain = cyc_pkg::cost_t'(st.remain + cyc_pkg::cost_t'(rn) - 10'h001); // RULE_13
                end else if (st.remain == 10'h001) begin
                    next_st.state = cyc_pkg::S_IDLE;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                    next_st.cycles = st.count + 10'h001;
                    next_st.trap = st.kind == cyc_pkg::K_PAGE_FAULT; // RULE_16
                    next_st.flush = is_entry(st.kind) || epu_instr(st.kind)
                                    || (st.kind == cyc_pkg::K_WRITE && st.wr_hit); // RULE_05 RULE_18
                    if (next_st.flush) begin
                        next_st.first = 1'b1;
                    end else if (st.kind inside {cyc_pkg::K_FETCH_CACHE, cyc_pkg::K_FETCH_EXT,
                                                 cyc_pkg::K_FETCH_BURST}) begin
                        next_st.first = 1'b0; // RULE_09
                    end
                end else begin
                    next_st.remain = st.remain - 10'h001;
                end
                if (st.ext && st.wait_lvl && st.bus_phase == 2'h0) begin
                    next_st.skip_wait = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
            st.first <= cyc_pkg::FIRST_PENDING_RST;
        end else begin
            st <= next_st;
        end
    end

    assign BUSY = st.busy;
    assign DONE = st.done;
    assign CYCLES = st.cycles;
    assign FLUSH = st.flush;
    assign TRAP_AV = st.trap;
    assign KWORDS = st.kwords;
    assign BLOCK_ADDR = st.block_addr;
    assign FILL_BYTES = st.fill;
    assign FOLLOW_FETCHES = st.follow_ifn;
    assign FIRST_PENDING = st.first;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_four_cycles_then_done;
        (!st.done)[*4] ##1 st.done;
    endsequence

    a_pause_hold: assert property ((st.state == cyc_pkg::S_RUN && st.pause_lvl && epu_instr(st.kind)) // RULE_01
        |=> st.remain == $past(st.remain)) else $error("pause did not hold count");
    a_template_cost: assert property ((start && kind_in == cyc_pkg::K_TEMPLATE) // RULE_02
        |=> st.remain == cyc_pkg::TEMPLATE && st.follow_ifn == ($past(aligned) ? 2'h1 : 2'h2))
        else $error("template cost wrong");
    a_kwords_odd: assert property ((start && kind_in == cyc_pkg::K_EPU_MEM && NBYTES[0]) // RULE_03
        |=> KWORDS == 8'(({1'b0, $past(NBYTES)} + 9'h001) >> 1)) else $error("word count wrong");
    a_addr_base_index: assert property ((start && kind_in == cyc_pkg::K_READ && !WORD && HIT_FIRST // RULE_04
        && ADDR_MODE == 2'h2) |=> st.remain == 10'h007) else $error("base index cost wrong");
    a_entry_flush: assert property ((st.done && is_entry(st.kind)) |-> st.flush) // RULE_05
        else $error("no flush after entry");
    a_trap_base: assert property ((start && kind_in == cyc_pkg::K_TRAP_SC) // RULE_06
        |=> st.remain == 10'h01E) else $error("system call base wrong");
    a_int_base: assert property ((start && kind_in == cyc_pkg::K_INT_M3V) // RULE_07
        |=> st.remain == 10'h01F) else $error("vectored interrupt base wrong");
    a_first_fetch: assert property ((start && kind_in == cyc_pkg::K_FETCH_CACHE && st.first) // RULE_09
        |=> s_four_cycles_then_done) else $error("first cached byte not 4 cycles");
    a_phase_bound: assert property ((start && kind_in == cyc_pkg::K_IN_EXT && RATIO == 2'h2) // RULE_10
        |=> st.remain >= 10'h014 && st.remain <= 10'h017) else $error("phase extra out of range");
    a_read_miss_miss: assert property ((start && kind_in == cyc_pkg::K_READ && WORD && !aligned // RULE_15
        && !HIT_FIRST && !HIT_SECOND && RATIO == 2'h0 && ADDR_MODE == 2'h0) |=> st.remain == 10'h00F)
        else $error("unaligned double miss cost wrong");
    a_fault_trap: assert property ((start && kind_in == cyc_pkg::K_PAGE_FAULT) // RULE_16
        |=> (!TRAP_AV)[*4] ##1 (TRAP_AV && DONE)) else $error("page fault trap timing wrong");
    a_write_flush: assert property ((st.done && st.kind == cyc_pkg::K_WRITE && st.wr_hit) |-> FLUSH) // RULE_18
        else $error("cached write did not flush");
endmodule // cyc_timer

// file: tb/bus_side.sv
// Purpose: Far-side stand-in that raises wait requests on the bus
// Assumes: Wait is a level seen through the block's synchroniser
// Notes: Wait and pause follow the bench's requests one clock later
`timescale 1ns/10ps
module bus_side (
    input wire logic CLK,       // Processor clock
    input wire logic wait_on,   // Bench asks for waits
    input wire logic pause_on,  // Bench asks for pause
    output logic WAIT_PIN,      // Wait request
    output logic PAUSE_PIN      // Pause request
);
    always_ff @(posedge CLK) begin
        WAIT_PIN <= wait_on;
        PAUSE_PIN <= pause_on;
    end
endmodule // bus_side

// file: tb/cpu_transaction_cycle_timing_test.sv
// Purpose: Self-checking bench for the cycle accountant
// Assumes: Inputs change at the falling edge, one request at a time
// Notes: Random address, mode and ratio from an LFSR
`timescale 1ns/10ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin err_total++; \
    $display("BAD %s exp %0d got %0d", nm, e, s); end end
module cpu_transaction_cycle_timing_test;
    logic CLK = 0, RST = 1, REQ = 0, WORD = 0, BUS16 = 0, HIT_FIRST = 1, HIT_SECOND = 1, pause_on = 0;
    logic WRITE_IN_CACHE = 0, WAIT_PIN, PAUSE_PIN, wait_on = 0, BUSY, DONE, FLUSH, TRAP_AV, FIRST_PENDING;
    logic [5:0] KIND = 0;
    logic [1:0] RATIO = 0, ADDR_MODE = 0, FOLLOW_FETCHES;
    logic [15:0] ADDR = 0, BLOCK_ADDR, lfsr = 16'h9934;
    logic [7:0] NBYTES = 0, KWORDS;
    logic [9:0] CYCLES;
    logic [2:0] FILL_BYTES;
    int err_total = 0, tests_run = 0, n, i;
    logic fl;
    cyc_timer dut_u (.CLK(CLK), .RST(RST), .REQ(REQ), .KIND(KIND), .RATIO(RATIO), .ADDR(ADDR), .WORD(WORD),
        .BUS16(BUS16), .HIT_FIRST(HIT_FIRST), .HIT_SECOND(HIT_SECOND), .ADDR_MODE(ADDR_MODE), .NBYTES(NBYTES),
        .WRITE_IN_CACHE(WRITE_IN_CACHE), .WAIT_PIN(WAIT_PIN), .PAUSE_PIN(PAUSE_PIN), .BUSY(BUSY), .DONE(DONE),
        .CYCLES(CYCLES), .FLUSH(FLUSH), .TRAP_AV(TRAP_AV), .KWORDS(KWORDS), .BLOCK_ADDR(BLOCK_ADDR),
        .FILL_BYTES(FILL_BYTES), .FOLLOW_FETCHES(FOLLOW_FETCHES), .FIRST_PENDING(FIRST_PENDING));
    bus_side far_u (.CLK(CLK), .wait_on(wait_on), .pause_on(pause_on), .WAIT_PIN(WAIT_PIN),
        .PAUSE_PIN(PAUSE_PIN));
    initial forever #4 CLK = ~CLK;
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Ratio-independent base costs
    function automatic int fixed_cost(input logic [5:0] k);
        case (k)
            cyc_pkg::K_TRAP_DIV_AV: return 25;
            cyc_pkg::K_TRAP_SC: return 30;
            cyc_pkg::K_INT_M2: return 16;
            cyc_pkg::K_INT_M3: return 28;
            cyc_pkg::K_INT_M3V: return 31;
            cyc_pkg::K_FATAL: return 15;
            cyc_pkg::K_RESET_PROC: return 3;
            cyc_pkg::K_HALT_TR: return 5;
            cyc_pkg::K_RESET_TR: return 6;
            cyc_pkg::K_IACK_NMI: return 4;
            cyc_pkg::K_IN_INT, cyc_pkg::K_OUT_INT: return 5;
            cyc_pkg::K_TEMPLATE: return 7;
            cyc_pkg::K_TEST_AND_SET_OP_FIXED: return 6;
            default: return 4;
        endcase
    endfunction
    task automatic go(input logic [5:0] k);
        KIND = k;
        REQ = 1;
        @(posedge CLK);
        @(negedge CLK);
        REQ = 0;
        n = 0;
        do begin @(negedge CLK); n++; end while (DONE !== 1'b1 && n < 400);
        fl = FLUSH;
        if (n >= 400) err_total++;
    endtask
    task automatic cost(input logic [5:0] k, input int e);
        go(k);
        `CHK("cycles", e, n)
        `CHK("cycles_out", e, int'(CYCLES))
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    logic [5:0] fk[15] = '{25, 27, 32, 33, 34, 35, 36, 18, 19, 15, 8, 10, 21, 5, 7};
    initial begin
        repeat (3) @(negedge CLK);
        RST = 0;
        `CHK("first_rst", 1'b1, FIRST_PENDING)
        cost(cyc_pkg::K_FETCH_CACHE, 4);
        cost(cyc_pkg::K_FETCH_CACHE, 1);
        for (i = 0; i < 15; i++) begin
            lfsr = nxt(lfsr);
            RATIO = lfsr[1:0];
            ADDR = lfsr;
            cost(fk[i], fixed_cost(fk[i]));
            if (fk[i] == cyc_pkg::K_PAGE_FAULT) `CHK("trap_av", 1'b1, TRAP_AV)
            if (i < 5) `CHK("flush_entry", 1'b1, fl)
        end
        `CHK("first_flush", 1'b1, FIRST_PENDING)
        cost(cyc_pkg::K_FETCH_CACHE, 4);
        RATIO = 0;
        cost(cyc_pkg::K_RETI_TR, 21);
        cost(cyc_pkg::K_EPU_WR, 10);
        cost(cyc_pkg::K_EPU_CPU, 9);
        cost(cyc_pkg::K_IACK_M123, 10);
        cost(cyc_pkg::K_IN_EXT, 9);
        for (i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            ADDR_MODE = lfsr[0] ? 2'h1 : 2'h2;
            NBYTES = lfsr[15:8];
            ADDR = {lfsr[15:1], 1'b0};
            BUS16 = 1;
            cost(cyc_pkg::K_READ, 5 + ADDR_MODE);
            cost(cyc_pkg::K_EPU_MEM, 5 + ADDR_MODE);
            `CHK("kwords", NBYTES[0] ? (NBYTES + 9'h1) >> 1 : NBYTES >> 1, KWORDS)
        end
        ADDR_MODE = 0;
        WORD = 1;
        ADDR = 16'h1235;
        cost(cyc_pkg::K_READ, 9);
        HIT_FIRST = 0;
        HIT_SECOND = 0;
        cost(cyc_pkg::K_READ, 15);
        cost(cyc_pkg::K_WRITE, 9);
        HIT_FIRST = 1;
        WRITE_IN_CACHE = 1;
        cost(cyc_pkg::K_WRITE, 10);
        `CHK("flush_wr", 1'b1, fl)
        cost(cyc_pkg::K_TEMPLATE, 7);
        `CHK("follow", 2'h2, FOLLOW_FETCHES)
        cost(cyc_pkg::K_FETCH_BURST, 12);
        `CHK("blk", 16'h1230, BLOCK_ADDR)
        `CHK("fill", 3'h7, FILL_BYTES)
        cost(cyc_pkg::K_FETCH_EXT, 5);
        `CHK("wblk", 16'h1234, BLOCK_ADDR)
        `CHK("wfill", 3'h1, FILL_BYTES)
        RATIO = 1;
        go(cyc_pkg::K_FETCH_EXT);
        `CHK("ratio2", 1'b1, n >= 8 && n <= 9)
        RATIO = 2;
        go(cyc_pkg::K_IN_EXT);
        `CHK("ratio4", 1'b1, n >= 20 && n <= 23)
        RATIO = 0;
        // Wait pin high for four clocks gives w of 4
        wait_on = 1;
        fork
            go(cyc_pkg::K_IN_EXT);
            begin
                repeat (4) @(negedge CLK);
                wait_on = 0;
            end
        join
        `CHK("waits", 9 + 4, n)
        // Pause pin high for three clocks, raised one clock before the request
        pause_on = 1;
        @(negedge CLK);
        fork
            go(cyc_pkg::K_EPU_INT);
            begin
                repeat (2) @(negedge CLK);
                pause_on = 0;
                `CHK("busy_pause", 1'b1, BUSY)
            end
        join
        `CHK("pause", 4 + 3, n)
        final_report();
    end
endmodule // cpu_transaction_cycle_timing_test
